// file: shared/ecwm_pkg.sv
/*
 * Shared constants, types and decode functions of the EEPROM configuration loader.
 * Assumes a single core clock; EEPROM words arrive as 16-bit values by even byte address.
 */
package ecwm_pkg;

   localparam int unsigned NPORTS = 4;
   localparam int unsigned EE_AW = 8;
   localparam int unsigned WORD_W = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // EEPROM word addresses (byte addressed, even)
   localparam logic [7:0] EE_ADDR_SIG = 8'h00;
   localparam logic [7:0] EE_ADDR_VID = 8'h02;
   localparam logic [7:0] EE_ADDR_DID = 8'h04;
   localparam logic [7:0] EE_ADDR_MODE = 8'h06;
   localparam logic [7:0] EE_ADDR_CAP = 8'h0c;

   // Source bit positions in word 06h
   localparam int unsigned W06_EXTVC = 0;
   localparam int unsigned W06_L0S_LO = 1;
   localparam int unsigned W06_L1_LO = 4;
   localparam int unsigned W06_NOORD_EGR = 8;
   localparam int unsigned W06_NOORD_TAG = 9;
   localparam int unsigned W06_SAF = 10;
   localparam int unsigned W06_CT_LO = 11;
   localparam int unsigned W06_ARB = 13;
   localparam int unsigned W06_CREDIT = 14;
   localparam int unsigned W06_INTA = 15;
   // Source bit positions in word 0Ch
   localparam int unsigned W0C_MPS_LO = 0;
   localparam int unsigned W0C_ASPM_LO = 2;

   // Destination bit positions inside the switch configuration registers
   localparam int unsigned EXTVC_BIT = 0;
   localparam int unsigned LCAP_ASPM_LO = 10;
   localparam int unsigned LCAP_L0S_LO = 12;
   localparam int unsigned LCAP_L1_LO = 15;
   localparam int unsigned SWM_SAF = 0;
   localparam int unsigned SWM_CT_LO = 1;
   localparam int unsigned SWM_ARB = 3;
   localparam int unsigned SWM_CREDIT = 4;
   localparam int unsigned SWM_NOORD_EGR = 5;
   localparam int unsigned SWM_NOORD_TAG = 6;
   localparam int unsigned INTPIN_BIT = 8;
   localparam int unsigned DCAP_MPS_LO = 0;

   // Hardware default contents of the packed words
   localparam logic [15:0] DEF_WORD_MODE = 16'h0806;
   localparam logic [15:0] DEF_WORD_CAP = 16'h4211;

   ////////////////////////////////////////////////////////////////////////////////
   // APB register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IDS = 8'h08;
   localparam logic [7:0] REG_SWMODE = 8'h0c;
   localparam logic [7:0] REG_LINKCAP = 8'h10;
   localparam logic [7:0] REG_DEVCAP = 8'h14;
   localparam logic [7:0] REG_EXTVC = 8'h18;
   localparam logic [7:0] REG_INTPIN = 8'h1c;
   localparam int unsigned CTRL_RELOAD = 0;
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_DONE = 1;
   localparam int unsigned STAT_SIG_OK = 2;
   localparam int unsigned STAT_ERR = 3;

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SIG = 6'h02,
      ST_VID = 6'h04,
      ST_DID = 6'h08,
      ST_MODE = 6'h10,
      ST_CAP = 6'h20
   } ecwm_state_t;

   typedef struct packed {
      logic ext_vc;
      logic [2:0] l0s_lat;
      logic [2:0] l1_lat;
      logic no_ord_egress;
      logic no_ord_tag;
      logic store_fwd;
      logic [1:0] ct_thresh;
      logic arb_mode;
      logic credit_mode;
      logic inta_req;
   } ecwm_mode_t;

   typedef struct packed {
      logic [1:0] aspm;
      logic [1:0] max_payload;
   } ecwm_cap_t;

   typedef struct packed {
      logic [15:0] vendor_id;
      logic [15:0] device_id;
      ecwm_mode_t mode;
      ecwm_cap_t cap;
   } ecwm_cfg_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ecwm_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ecwm_apb_rsp_t;

   function automatic ecwm_mode_t ecwm_decode_mode(input logic [15:0] w);
      ecwm_mode_t m;
      m.ext_vc = w[W06_EXTVC];
      m.l0s_lat = w[W06_L0S_LO +: 3];
      m.l1_lat = w[W06_L1_LO +: 3];
      m.no_ord_egress = w[W06_NOORD_EGR];
      m.no_ord_tag = w[W06_NOORD_TAG];
      m.store_fwd = w[W06_SAF];
      m.ct_thresh = w[W06_CT_LO +: 2];
      m.arb_mode = w[W06_ARB];
      m.credit_mode = w[W06_CREDIT];
      m.inta_req = w[W06_INTA];
      return m;
   endfunction : ecwm_decode_mode

   function automatic ecwm_cap_t ecwm_decode_cap(input logic [15:0] w);
      ecwm_cap_t c;
      c.max_payload = w[W0C_MPS_LO +: 2];
      c.aspm = w[W0C_ASPM_LO +: 2];
      return c;
   endfunction : ecwm_decode_cap

endpackage : ecwm_pkg

// file: core/ecwm_word_fetch.sv
/*
 * One EEPROM word read: request/valid handshake with a timeout.
 * Assumes the EEPROM side answers with ee_valid and data while ee_req is high.
 */
`timescale 1ns/1ps
module ecwm_word_fetch #(
   parameter int unsigned TIMEOUT_CYC = 1024
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Loader side
   input wire logic go,
   input wire logic [7:0] go_addr,
   output logic done,
   output logic err,
   output logic [15:0] data,
   // EEPROM side
   output logic ee_req,
   output logic [7:0] ee_addr,
   input wire logic ee_valid,
   input wire logic [15:0] ee_rdata
);

   typedef struct packed {
      logic req;
      logic [7:0] addr;
      logic [15:0] data;
      logic done;
      logic err;
      logic [$clog2(TIMEOUT_CYC+1)-1:0] cnt;
   } ecwm_fetch_st_t;

   ecwm_fetch_st_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.err = 1'b0;
      if (go && !s_q.req)
      begin
         s_d.req = 1'b1;
         s_d.addr = go_addr;
         s_d.cnt = '0;
      end
      else if (s_q.req)
      begin
         if (ee_valid)
         begin
            s_d.req = 1'b0;
            s_d.data = ee_rdata;
            s_d.done = 1'b1;
         end
         // A dead EEPROM must not hang the switch in defaults forever
         else if (s_q.cnt == ($clog2(TIMEOUT_CYC+1))'(TIMEOUT_CYC - 1))
         begin
            s_d.req = 1'b0;
            s_d.err = 1'b1;
         end
         else
         begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
   assign err = s_q.err;
   assign data = s_q.data;
   assign ee_req = s_q.req;
   assign ee_addr = s_q.addr;

endmodule : ecwm_word_fetch

// file: core/ecwm_loader.sv
/*
 * EEPROM configuration loader of a four-port switch, with an APB register view.
 * Assumes one core clock, APB master synchronous to it, EEPROM reached through ecwm_word_fetch.
 */
// Operation
// - Word 06h bit 0 becomes the extended channel count bit 0 of register 144h on every port.
// - Word 06h bits 3..1 become link capability bits 14..12 (L0s exit latency) on all ports.
// - Word 06h bits 6..4 become link capability bits 17..15 (L1 exit latency) on all ports.
// - Word 06h bit 8 becomes switch-mode bit 5, dropping ordering between different egress ports.
// - Word 06h bit 9 becomes switch-mode bit 6, dropping ordering between completions of different tags.
// - Word 06h bit 10 becomes switch-mode bit 0, selecting store-and-forward.
// - Word 06h bits 12..11 become switch-mode bits 2..1, the cut-through threshold.
// - Word 06h bit 13 becomes switch-mode bit 3, the port arbitration scheme.
// - Word 06h bit 14 becomes switch-mode bit 4, the credit update mode.
// - Word 06h bit 15 becomes interrupt pin bit 8 of ports 1 to 3, requesting INTA.
// - Word 0Ch bits 1..0 become device capability bits 1..0, the largest payload, on all ports.
// - Word 0Ch bits 3..2 become link capability bits 11..10, the ASPM support level, on all ports.
`timescale 1ns/1ps
module ecwm_loader #(
   parameter int unsigned NPORTS = ecwm_pkg::NPORTS,
   parameter int unsigned TIMEOUT_CYC = 1024,
   // Arbitrary neutral values
   parameter logic [15:0] SIGNATURE = 16'h5aa5,
   parameter logic [15:0] DEF_VENDOR_ID = 16'h0001,
   parameter logic [15:0] DEF_DEVICE_ID = 16'h0002
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire ecwm_pkg::ecwm_apb_req_t apb_req,
   output ecwm_pkg::ecwm_apb_rsp_t apb_rsp,
   // EEPROM word port
   output logic ee_req,
   output logic [7:0] ee_addr,
   input wire logic ee_valid,
   input wire logic [15:0] ee_rdata,
   // Loaded configuration
   output ecwm_pkg::ecwm_cfg_t cfg,
   output logic [NPORTS-1:0] intpin_inta,
   output logic load_busy,
   output logic load_done,
   output logic sig_ok
);

   typedef struct packed {
      ecwm_pkg::ecwm_state_t st;
      logic go;
      logic [7:0] go_addr;
      logic start_pend;
      logic sig_ok;
      logic done;
      logic err;
      logic busy;
      ecwm_pkg::ecwm_cfg_t cfg;
      logic [NPORTS-1:0] intpin;
      ecwm_pkg::ecwm_apb_rsp_t apb;
   } ecwm_main_st_t;

   ecwm_main_st_t s_q, s_d;
   logic f_done;
   logic f_err;
   logic [15:0] f_data;

   ////////////////////////////////////////////////////////////////////////////////
   // Defaults and register decode

   function automatic ecwm_pkg::ecwm_cfg_t def_cfg();
      ecwm_pkg::ecwm_cfg_t c;
      c.vendor_id = DEF_VENDOR_ID;
      c.device_id = DEF_DEVICE_ID;
      c.mode = ecwm_pkg::ecwm_decode_mode(ecwm_pkg::DEF_WORD_MODE);
      c.cap = ecwm_pkg::ecwm_decode_cap(ecwm_pkg::DEF_WORD_CAP);
      return c;
   endfunction : def_cfg

   function automatic logic [NPORTS-1:0] def_intpin();
      logic [NPORTS-1:0] p;
      p = {NPORTS{ecwm_pkg::ecwm_decode_mode(ecwm_pkg::DEF_WORD_MODE).inta_req}};
      p[0] = 1'b0;
      return p;
   endfunction : def_intpin

   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == ecwm_pkg::REG_CTRL) || (a == ecwm_pkg::REG_STATUS) || (a == ecwm_pkg::REG_IDS)
         || (a == ecwm_pkg::REG_SWMODE) || (a == ecwm_pkg::REG_LINKCAP) || (a == ecwm_pkg::REG_DEVCAP)
         || (a == ecwm_pkg::REG_EXTVC) || (a == ecwm_pkg::REG_INTPIN);
   endfunction : addr_mapped

   ////////////////////////////////////////////////////////////////////////////////
   // EEPROM word reader

   ecwm_word_fetch #(
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_fetch (
      .clk(clk),
      .rst(rst),
      .go(s_q.go),
      .go_addr(s_q.go_addr),
      .done(f_done),
      .err(f_err),
      .data(f_data),
      .ee_req(ee_req),
      .ee_addr(ee_addr),
      .ee_valid(ee_valid),
      .ee_rdata(ee_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic [31:0] rd;
      logic busy;
      rd = '0;
      busy = (s_q.st != ecwm_pkg::ST_IDLE);
      s_d = s_q;
      s_d.go = 1'b0;

      // Load sequence
      case (s_q.st)
         ecwm_pkg::ST_IDLE:
         begin
            if (s_q.start_pend)
            begin
               s_d.start_pend = 1'b0;
               // Reload starts from defaults so a bad signature leaves nothing stale
               s_d.cfg = def_cfg();
               s_d.intpin = def_intpin();
               s_d.sig_ok = 1'b0;
               s_d.done = 1'b0;
               s_d.err = 1'b0;
               s_d.go = 1'b1;
               s_d.go_addr = ecwm_pkg::EE_ADDR_SIG;
               s_d.st = ecwm_pkg::ST_SIG;
            end
         end
         ecwm_pkg::ST_SIG:
         begin
            if (f_done)
            begin
               if (f_data == SIGNATURE)
               begin
                  s_d.sig_ok = 1'b1;
                  s_d.go = 1'b1;
                  s_d.go_addr = ecwm_pkg::EE_ADDR_VID;
                  s_d.st = ecwm_pkg::ST_VID;
               end
               else
               begin
                  s_d.done = 1'b1;
                  s_d.st = ecwm_pkg::ST_IDLE;
               end
            end
         end
         ecwm_pkg::ST_VID:
         begin
            if (f_done)
            begin
               s_d.cfg.vendor_id = f_data;
               s_d.go = 1'b1;
               s_d.go_addr = ecwm_pkg::EE_ADDR_DID;
               s_d.st = ecwm_pkg::ST_DID;
            end
         end
         ecwm_pkg::ST_DID:
         begin
            if (f_done)
            begin
               s_d.cfg.device_id = f_data;
               s_d.go = 1'b1;
               s_d.go_addr = ecwm_pkg::EE_ADDR_MODE;
               s_d.st = ecwm_pkg::ST_MODE;
            end
         end
         ecwm_pkg::ST_MODE:
         begin
            if (f_done)
            begin
               // One decode feeds every port image
               s_d.cfg.mode = ecwm_pkg::ecwm_decode_mode(f_data);
               s_d.intpin = {NPORTS{f_data[ecwm_pkg::W06_INTA]}};
               s_d.intpin[0] = 1'b0;
               s_d.go = 1'b1;
               s_d.go_addr = ecwm_pkg::EE_ADDR_CAP;
               s_d.st = ecwm_pkg::ST_CAP;
            end
         end
         ecwm_pkg::ST_CAP:
         begin
            if (f_done)
            begin
               s_d.cfg.cap = ecwm_pkg::ecwm_decode_cap(f_data);
               s_d.done = 1'b1;
               s_d.st = ecwm_pkg::ST_IDLE;
            end
         end
         default:
         begin
            s_d.st = ecwm_pkg::ST_IDLE;
         end
      endcase

      // Timeout aborts; words already taken stay, status shows the error
      if (f_err && busy)
      begin
         s_d.err = 1'b1;
         s_d.done = 1'b1;
         s_d.st = ecwm_pkg::ST_IDLE;
      end

      // Register images
      case (apb_req.paddr)
         ecwm_pkg::REG_STATUS:
         begin
            rd[ecwm_pkg::STAT_BUSY] = busy;
            rd[ecwm_pkg::STAT_DONE] = s_q.done;
            rd[ecwm_pkg::STAT_SIG_OK] = s_q.sig_ok;
            rd[ecwm_pkg::STAT_ERR] = s_q.err;
         end
         ecwm_pkg::REG_IDS:
         begin
            rd = {s_q.cfg.device_id, s_q.cfg.vendor_id};
         end
         ecwm_pkg::REG_SWMODE:
         begin
            rd[ecwm_pkg::SWM_SAF] = s_q.cfg.mode.store_fwd;
            rd[ecwm_pkg::SWM_CT_LO +: 2] = s_q.cfg.mode.ct_thresh;
            rd[ecwm_pkg::SWM_ARB] = s_q.cfg.mode.arb_mode;
            rd[ecwm_pkg::SWM_CREDIT] = s_q.cfg.mode.credit_mode;
            rd[ecwm_pkg::SWM_NOORD_EGR] = s_q.cfg.mode.no_ord_egress;
            rd[ecwm_pkg::SWM_NOORD_TAG] = s_q.cfg.mode.no_ord_tag;
         end
         ecwm_pkg::REG_LINKCAP:
         begin
            rd[ecwm_pkg::LCAP_ASPM_LO +: 2] = s_q.cfg.cap.aspm;
            rd[ecwm_pkg::LCAP_L0S_LO +: 3] = s_q.cfg.mode.l0s_lat;
            rd[ecwm_pkg::LCAP_L1_LO +: 3] = s_q.cfg.mode.l1_lat;
         end
         ecwm_pkg::REG_DEVCAP:
         begin
            rd[ecwm_pkg::DCAP_MPS_LO +: 2] = s_q.cfg.cap.max_payload;
         end
         ecwm_pkg::REG_EXTVC:
         begin
            rd[ecwm_pkg::EXTVC_BIT] = s_q.cfg.mode.ext_vc;
         end
         ecwm_pkg::REG_INTPIN:
         begin
            rd[ecwm_pkg::INTPIN_BIT +: NPORTS] = s_q.intpin;
         end
         default:
         begin
            rd = '0;
         end
      endcase

      // APB: answer prepared in setup, completes at the first access edge
      if (apb_req.psel && !apb_req.penable && !s_q.apb.pready)
      begin
         s_d.apb.pready = 1'b1;
         s_d.apb.pslverr = !addr_mapped(apb_req.paddr);
         s_d.apb.prdata = apb_req.pwrite ? 32'h0000_0000 : rd;
      end
      else if (apb_req.psel && apb_req.penable && s_q.apb.pready)
      begin
         s_d.apb.pready = 1'b0;
         s_d.apb.pslverr = 1'b0;
         s_d.apb.prdata = '0;
         // Reload request while idle; set wins over the idle-state consume
         if (apb_req.pwrite && (apb_req.paddr == ecwm_pkg::REG_CTRL)
            && apb_req.pwdata[ecwm_pkg::CTRL_RELOAD] && !busy)
         begin
            s_d.start_pend = 1'b1;
         end
      end
      else
      begin
         s_d.apb.pready = 1'b0;
         s_d.apb.pslverr = 1'b0;
         s_d.apb.prdata = '0;
      end

      // Busy is kept as its own flop so the port needs no decode
      s_d.busy = (s_d.st != ecwm_pkg::ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q.st <= ecwm_pkg::ST_IDLE;
         s_q.go <= 1'b0;
         s_q.go_addr <= ecwm_pkg::EE_ADDR_SIG;
         // Load runs once by itself after reset
         s_q.start_pend <= 1'b1;
         s_q.sig_ok <= 1'b0;
         s_q.done <= 1'b0;
         s_q.err <= 1'b0;
         s_q.busy <= 1'b0;
         s_q.cfg <= def_cfg();
         s_q.intpin <= def_intpin();
         s_q.apb <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign apb_rsp = s_q.apb;
   assign cfg = s_q.cfg;
   assign intpin_inta = s_q.intpin;
   assign load_busy = s_q.busy;
   assign load_done = s_q.done;
   assign sig_ok = s_q.sig_ok;

endmodule : ecwm_loader

// file: verif/ecwm_loader_props.sv
/*
 * Port checker of the EEPROM configuration loader.
 * Assumes one core clock with async high reset; attached by the bind at the foot.
 */
`timescale 1ns/1ps
module ecwm_loader_props #(
   parameter int unsigned NPORTS = 4,
   parameter logic [15:0] SIGNATURE = 16'h5aa5,
   parameter logic [15:0] DEF_VENDOR_ID = 16'h0001,
   parameter logic [15:0] DEF_DEVICE_ID = 16'h0002
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // EEPROM port
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   input wire logic ee_valid,
   input wire logic [15:0] ee_rdata,
   // Loaded state
   input wire ecwm_pkg::ecwm_cfg_t cfg,
   input wire logic [NPORTS-1:0] intpin_inta,
   input wire logic load_busy,
   input wire logic load_done,
   input wire logic sig_ok
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   // Last accepted word, so the field checks compare against what really arrived
   logic [15:0] w_q;
   always_ff @(posedge clk or posedge rst)
      if (rst)
         w_q <= 16'h0000;
      else if (ee_req && ee_valid)
         w_q <= ee_rdata;

   sequence s_word(logic [7:0] a);
      ee_req && ee_valid && ee_addr == a;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   a_sig_first: assert property ($rose(load_busy) |-> ##[0:2] (ee_req && ee_addr == 8'h00))
      else $error("load did not begin with word 00");
   a_sig_reject: assert property (s_word(8'h00) ##0 (ee_rdata != SIGNATURE) |-> ##[1:3]
      (load_done && !sig_ok && !ee_req && cfg.vendor_id == DEF_VENDOR_ID && cfg.device_id == DEF_DEVICE_ID
       && cfg.mode.store_fwd == ecwm_pkg::DEF_WORD_MODE[10] && intpin_inta == '0))
      else $error("bad signature did not stop the load at defaults");
   a_vid_load: assert property (s_word(8'h02) |-> ##[1:3] cfg.vendor_id == w_q)
      else $error("vendor id not loaded");
   a_did_load: assert property (s_word(8'h04) |-> ##[1:3] cfg.device_id == w_q)
      else $error("device id not loaded");
   a_lat_bits: assert property (s_word(8'h06) |-> ##[1:3] (cfg.mode.ext_vc == w_q[0]
      && cfg.mode.l0s_lat == w_q[3:1] && cfg.mode.l1_lat == w_q[6:4]))
      else $error("channel or latency fields wrong");
   a_swmode_bits: assert property (s_word(8'h06) |-> ##[1:3] (cfg.mode.no_ord_egress == w_q[8]
      && cfg.mode.no_ord_tag == w_q[9] && cfg.mode.store_fwd == w_q[10] && cfg.mode.ct_thresh == w_q[12:11]
      && cfg.mode.arb_mode == w_q[13] && cfg.mode.credit_mode == w_q[14]))
      else $error("switch mode fields wrong");
   a_inta_ports: assert property (s_word(8'h06) |-> ##[1:3] intpin_inta == {{(NPORTS-1){w_q[15]}}, 1'b0})
      else $error("interrupt pin image wrong");
   a_cap_bits: assert property (s_word(8'h0c) |-> ##[1:3]
      (cfg.cap.max_payload == w_q[1:0] && cfg.cap.aspm == w_q[3:2]))
      else $error("capability fields wrong");
endmodule : ecwm_loader_props

bind ecwm_loader ecwm_loader_props #(.NPORTS(NPORTS), .SIGNATURE(SIGNATURE), .DEF_VENDOR_ID(DEF_VENDOR_ID),
   .DEF_DEVICE_ID(DEF_DEVICE_ID)) u_ecwm_loader_props (.clk(clk), .rst(rst), .ee_req(ee_req),
   .ee_addr(ee_addr), .ee_valid(ee_valid), .ee_rdata(ee_rdata), .cfg(cfg), .intpin_inta(intpin_inta),
   .load_busy(load_busy), .load_done(load_done), .sig_ok(sig_ok));

// file: verif/ecwm_ee_model.sv
/*
 * Behavioural EEPROM word store answering the loader's word requests.
 * Assumes the bench fills mem between loads; dly sets the answer delay, mute withholds answers.
 */
`timescale 1ns/1ps
module ecwm_ee_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Word port
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   output logic ee_valid,
   output logic [15:0] ee_rdata,
   // Bench control
   input wire logic mute,
   input wire logic [1:0] dly
);
   logic [15:0] mem [0:7];
   logic [1:0] cnt_q;

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         ee_valid <= 1'b0;
         ee_rdata <= 16'hffff;
         cnt_q <= 2'h0;
      end
      else
      begin
         ee_valid <= 1'b0;
         // Data toggles outside the strobe so a held value is never mistaken for valid
         ee_rdata <= ~ee_rdata;
         if (ee_req && !ee_valid && !mute)
         begin
            if (cnt_q == dly)
            begin
               ee_valid <= 1'b1;
               ee_rdata <= mem[ee_addr[3:1]];
               cnt_q <= 2'h0;
            end
            else
               cnt_q <= cnt_q + 2'h1;
         end
      end
endmodule : ecwm_ee_model

// file: verif/test_eeprom_config_word_mapper.sv
/*
 * Self-checking bench of the EEPROM configuration loader over APB.
 * Assumes the loader starts a load by itself after reset and reloads on a CTRL write.
 */
`timescale 1ns/1ps
module test_eeprom_config_word_mapper;
   // Arbitrary values
   localparam logic [15:0] SIG = 16'hc3a5;
   localparam logic [15:0] DVID = 16'h0a0b;
   localparam logic [15:0] DDID = 16'h0c0d;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic mute = 1'b0;
   logic [1:0] dly = 2'h0;
   ecwm_pkg::ecwm_apb_req_t apb_req = '0;
   ecwm_pkg::ecwm_apb_rsp_t apb_rsp;
   ecwm_pkg::ecwm_cfg_t cfg;
   logic ee_req, ee_valid, load_busy, load_done, sig_ok, er;
   logic [7:0] ee_addr;
   logic [15:0] ee_rdata, v, d, w, c;
   logic [3:0] intpin_inta;
   logic [31:0] rd;
   int failures = 0;
   int comparisons = 0;

   always #12.5 clk = ~clk;

   ecwm_loader #(.TIMEOUT_CYC(16), .SIGNATURE(SIG), .DEF_VENDOR_ID(DVID), .DEF_DEVICE_ID(DDID)) u_ecwm_loader (
      .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .ee_req(ee_req), .ee_addr(ee_addr),
      .ee_valid(ee_valid), .ee_rdata(ee_rdata), .cfg(cfg), .intpin_inta(intpin_inta), .load_busy(load_busy),
      .load_done(load_done), .sig_ok(sig_ok));
   ecwm_ee_model u_ecwm_ee_model (.clk(clk), .rst(rst), .ee_req(ee_req), .ee_addr(ee_addr),
      .ee_valid(ee_valid), .ee_rdata(ee_rdata), .mute(mute), .dly(dly));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (apb_rsp.pready !== 1'b1 && n < 50);
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req <= '0;
      if (n >= 50)
      begin
         failures++;
         final_report();
      end
   endtask : apb

   task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, rd, exp);
   endtask : rchk

   task automatic wait_done;
      int n;
      n = 0;
      // Done from the previous load stays up until the new load starts
      repeat (2) @(posedge clk);
      while (!(load_done === 1'b1 && load_busy === 1'b0) && n < 500)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 500)
      begin
         failures++;
         final_report();
      end
   endtask : wait_done

   function automatic logic [31:0] exp_sw(input logic [15:0] m);
      return {25'h0, m[9], m[8], m[14], m[13], m[12:11], m[10]};
   endfunction : exp_sw

   function automatic logic [31:0] exp_lcap(input logic [15:0] m, input logic [15:0] k);
      return {14'h0, m[6:4], m[3:1], k[3:2], 10'h0};
   endfunction : exp_lcap

   task automatic check_regs(input logic [15:0] ev, ed, m, k, input logic [31:0] st);
      rchk("status", ecwm_pkg::REG_STATUS, st);
      rchk("ids", ecwm_pkg::REG_IDS, {ed, ev});
      rchk("extvc", ecwm_pkg::REG_EXTVC, {31'h0, m[0]});
      rchk("linkcap", ecwm_pkg::REG_LINKCAP, exp_lcap(m, k));
      rchk("swmode", ecwm_pkg::REG_SWMODE, exp_sw(m));
      rchk("intpin", ecwm_pkg::REG_INTPIN, {20'h0, {3{m[15]}}, 1'b0, 8'h0});
      chk("intpin_port", {28'h0, intpin_inta}, {28'h0, {3{m[15]}}, 1'b0});
      rchk("devcap", ecwm_pkg::REG_DEVCAP, {30'h0, k[1:0]});
   endtask : check_regs

   task automatic fill(input logic [15:0] s);
      u_ecwm_ee_model.mem[0] = s;
      u_ecwm_ee_model.mem[1] = v;
      u_ecwm_ee_model.mem[2] = d;
      u_ecwm_ee_model.mem[3] = w;
      u_ecwm_ee_model.mem[6] = c;
   endtask : fill

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h77e237b0));
      {v, d, w, c} = {$urandom, $urandom};
      fill(SIG);
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_done();
      check_regs(v, d, w, c, 32'h6);
      for (int i = 0; i < 8; i++)
      begin
         {v, d, w, c} = {$urandom, $urandom};
         if (i == 0)
            {w, c} = 32'hffff_000f;
         if (i == 1)
            {w, c} = 32'h0;
         // One bit off the signature must leave every field at default
         fill(i == 3 ? SIG ^ 16'h0001 : SIG);
         dly <= 2'($urandom_range(3));
         apb(1'b1, ecwm_pkg::REG_CTRL, 32'h1);
         wait_done();
         if (i == 3)
            check_regs(DVID, DDID, ecwm_pkg::DEF_WORD_MODE, ecwm_pkg::DEF_WORD_CAP, 32'h2);
         else
            check_regs(v, d, w, c, 32'h6);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped_err", {31'h0, er}, 32'h1);
      chk("unmapped_data", rd, 32'h0);
      apb(1'b1, ecwm_pkg::REG_IDS, 32'hffff_ffff);
      chk("write_rdata", rd, 32'h0);
      chk("write_err", {31'h0, er}, 32'h0);
      rchk("ids_ro", ecwm_pkg::REG_IDS, {d, v});
      mute <= 1'b1;
      apb(1'b1, ecwm_pkg::REG_CTRL, 32'h1);
      // Second reload lands while busy and must be dropped
      apb(1'b1, ecwm_pkg::REG_CTRL, 32'h1);
      wait_done();
      check_regs(DVID, DDID, ecwm_pkg::DEF_WORD_MODE, ecwm_pkg::DEF_WORD_CAP, 32'ha);
      final_report();
   end
endmodule : test_eeprom_config_word_mapper
